//--- rtl/rcc_pkg.sv
// Purpose: Constants shared by the calendar, timebase and control block
// Assumes: 10 MHz system clock, 32.768 kHz equivalent timebase
// Notes: Indexes sit behind an index/data I/O port pair
package rcc_pkg;
   // I/O ports of the index/data pair
   localparam logic [7:0] PORT_INDEX = 8'h70;
   localparam logic [7:0] PORT_DATA = 8'h71;
   // Register indexes
   localparam logic [7:0] IDX_MONTH = 8'h08;
   localparam logic [7:0] IDX_YEAR = 8'h09;
   localparam logic [7:0] IDX_CTLA = 8'h0A;
   localparam logic [7:0] IDX_CTLB = 8'h0B;
   localparam logic [7:0] IDX_STATC = 8'h0C;
   // Control A fields
   localparam int CTLA_UIP_BIT = 7;
   localparam int CTLA_DCTL_LSB = 4;
   localparam int CTLA_RATE_LSB = 0;
   // Control B fields
   localparam int CTLB_SET_BIT = 7;
   localparam int CTLB_PER_EN_BIT = 6;
   localparam int CTLB_ALM_EN_BIT = 5;
   localparam int CTLB_UPD_EN_BIT = 4;
   localparam int CTLB_BIN_BIT = 2;
   localparam int CTLB_H24_BIT = 1;
   localparam int CTLB_DST_BIT = 0;
   // Status C fields
   localparam int STATC_INT_BIT = 7;
   localparam int STATC_PER_BIT = 6;
   localparam int STATC_ALM_BIT = 5;
   localparam int STATC_UPD_BIT = 4;
   // Divider chain control codes
   localparam logic [2:0] DCTL_NORMAL = 3'h2;
   localparam logic [1:0] DCTL_HOLD_HI = 2'h3;
   // Calendar limits
   localparam logic [7:0] MONTH_FIRST = 8'h01;
   localparam logic [7:0] MONTH_LAST_BIN = 8'h0C;
   localparam logic [7:0] MONTH_LAST_BCD = 8'h12;
   localparam logic [7:0] YEAR_FIRST = 8'h00;
   localparam logic [7:0] YEAR_LAST_BIN = 8'h63;
   localparam logic [7:0] YEAR_LAST_BCD = 8'h99;
   // Timing
   localparam longint CLK_HZ = 10000000;
   localparam longint TB_HZ = 32768;
   localparam longint UIP_WINDOW_US = 244;
   localparam longint HOLD_RELEASE_MS = 500;
   localparam int CHAIN_W = 15;
   localparam int ACC_W = 24;
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TB_HZ);
   localparam logic [ACC_W-1:0] ACC_LIMIT = ACC_W'(CLK_HZ);
   localparam logic [CHAIN_W-1:0] UIP_TICKS =
      CHAIN_W'((UIP_WINDOW_US * TB_HZ + 999999) / 1000000);
   localparam logic [CHAIN_W-1:0] CHAIN_LAST = 15'h7FFF;
   localparam logic [CHAIN_W-1:0] UIP_START = CHAIN_LAST - UIP_TICKS + 15'h0001;
   localparam logic [CHAIN_W-1:0] CHAIN_RELEASE =
      CHAIN_W'(32'(TB_HZ) - 32'(HOLD_RELEASE_MS * TB_HZ / 1000));
   localparam logic [CHAIN_W-1:0] CHAIN_RESET = CHAIN_RELEASE;
endpackage : rcc_pkg

//--- rtl/rcc_top.sv
// Purpose: Month/year calendar, divider chain, update flag, periodic events
// Assumes: Day rollover arrives from the time-of-day logic as a carry pulse
// Notes: Divider control, encoding and mode bits and the calendar keep
//    their value through rst; rst acts as the clock-only reset

module rcc_top
   import rcc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // I/O port access
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   // Neighbouring clock logic
   input wire logic month_carry,
   input wire logic alarm_event,
   input wire logic update_end_event,
   output logic update_strobe,
   output logic [7:0] month_value,
   output logic [7:0] year_value,
   output logic calendar_binary,
   output logic hour_24,
   output logic dst_enable,
   // Interrupt request to the interrupt controller
   output logic irq
);
   import rcc_pkg::*;

   typedef struct packed {
      // Software-visible registers
      logic [7:0] idx;
      logic [7:0] month;
      logic [7:0] year;
      logic [2:0] dctl;
      logic [3:0] rate;

      // Control B bits
      logic set_b;
      logic per_en;
      logic alm_en;
      logic upd_en;
      logic date_bin;
      logic hour24;
      logic ds_en;

      // Timebase and divider chain
      logic [CHAIN_W-1:0] chain;
      logic [ACC_W-1:0] acc;
      logic update_in_progress_flag;

      // Latched event flags of status C
      logic per_flg;
      logic alm_flg;
      logic upd_flg;
      logic summary_irq_flag;

      // Port answer and update pulse
      logic [7:0] rdata;
      logic rvalid;
      logic upd_pulse;
   } rcc_state_t;

   rcc_state_t st_reg;
   rcc_state_t st_next;

   // One calendar step; returns carry and next value
   // Out-of-range values simply count up through FFh and wrap to zero,
   // which lands year back in the legal range, and month one step later at 01, without special handling
   function automatic logic [8:0] cal_step(input logic [7:0] v, input logic bin,
                                           input logic [7:0] last,
                                           input logic [7:0] first);
      logic [7:0] hi_inc;
      hi_inc = {v[7:4] + 4'h1, 4'h0};
      if (v == last) begin
         cal_step = {1'b1, first};
      end else if (bin || v[3:0] != 4'h9) begin
         cal_step = {1'b0, v + 8'h01};
      end else begin
         cal_step = {1'b0, hi_inc};
      end
   endfunction

   // Tap of the chain for a rate code; zero means disabled
   // Codes 1 and 2 reuse the taps of codes 8 and 9
   function automatic logic [3:0] rate_tap(input logic [3:0] code);
      case (code)
         4'h0: rate_tap = 4'h0;
         4'h1: rate_tap = 4'h7;
         4'h2: rate_tap = 4'h8;
         default: rate_tap = code - 4'h1;
      endcase
   endfunction

   // Timebase and divider chain
   logic tb_tick;
   logic chain_hold;
   logic chain_normal;
   logic chain_step;
   logic chain_wrap;
   logic [ACC_W-1:0] acc_sum;

   // Periodic event
   logic [3:0] tap;
   logic [CHAIN_W-1:0] tap_mask;
   logic per_evt;

   // Update and calendar step
   logic do_update;
   logic [8:0] mon_res;
   logic [8:0] yr_res;

   // Summary flag causes
   logic per_rise;
   logic alm_rise;
   logic upd_rise;
   logic per_late;
   logic alm_late;
   logic upd_late;

   // Port decode and read mux
   logic wr_idx;
   logic wr_data;
   logic rd_data;
   logic rd_idx;
   logic [7:0] rd_val;

   always_comb begin
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      st_next.upd_pulse = 1'b0;

      // Port decode; any other address is ignored
      wr_idx = io_wr && io_addr == PORT_INDEX;
      wr_data = io_wr && io_addr == PORT_DATA;
      rd_idx = io_rd && io_addr == PORT_INDEX;
      rd_data = io_rd && io_addr == PORT_DATA;

      // Timebase: fractional accumulator gives 32.768 kHz enables
      // The remainder spreads the ticks evenly, so a second has no drift
      acc_sum = st_reg.acc + ACC_STEP;
      tb_tick = acc_sum >= ACC_LIMIT;
      st_next.acc = tb_tick ? acc_sum - ACC_LIMIT : acc_sum;

      chain_hold = st_reg.dctl[2:1] == DCTL_HOLD_HI;
      chain_normal = st_reg.dctl == DCTL_NORMAL;
      // Reserved codes step the chain every clock, far above 1 Hz
      chain_step = chain_normal ? tb_tick : !chain_hold;
      chain_wrap = chain_step && st_reg.chain == CHAIN_LAST;

      // Hold rewrites the parked value every cycle, so a release always
      // starts 16384 chain steps before the next wrap, half a second in normal mode
      if (chain_hold) begin
         // Parked half a second before the wrap
         st_next.chain = CHAIN_RELEASE;
      end else if (chain_step) begin
         st_next.chain = st_reg.chain + 15'h0001;
      end

      // Periodic event from the selected chain tap
      tap = rate_tap(st_reg.rate);
      tap_mask = (15'h0001 << tap) - 15'h0001;
      // A tap fires when the low bits all read one on a step
      per_evt = chain_step && tap != 4'h0 &&
                (st_reg.chain & tap_mask) == tap_mask;

      // Update at chain wrap unless inhibited
      do_update = chain_wrap && !st_reg.set_b;
      // Flag rises a few ticks before the wrap, so software is warned
      // before the registers move; it lags the chain by one clock
      st_next.update_in_progress_flag = !st_reg.set_b && !chain_hold && !chain_wrap &&
                    st_reg.chain >= UIP_START;
      if (do_update) begin
         st_next.upd_pulse = 1'b1;
      end

      // Month and year advance on the day carry
      mon_res = cal_step(st_reg.month, st_reg.date_bin,
                         st_reg.date_bin ? MONTH_LAST_BIN : MONTH_LAST_BCD,
                         MONTH_FIRST);
      yr_res = cal_step(st_reg.year, st_reg.date_bin,
                        st_reg.date_bin ? YEAR_LAST_BIN : YEAR_LAST_BCD,
                        YEAR_FIRST);
      // A data write in the same cycle is applied later and wins
      if (month_carry && !st_reg.set_b) begin
         st_next.month = mon_res[7:0];
         if (mon_res[8]) begin
            st_next.year = yr_res[7:0];
         end
      end

      // Read: status C clears on read, a new event wins
      rd_val = 8'h00;
      case (st_reg.idx)
         IDX_MONTH: rd_val = st_reg.month;
         IDX_YEAR: rd_val = st_reg.year;
         IDX_CTLA: rd_val = {st_reg.update_in_progress_flag, st_reg.dctl, st_reg.rate};
         IDX_CTLB: rd_val = {st_reg.set_b, st_reg.per_en, st_reg.alm_en,
                             st_reg.upd_en, 1'b0, st_reg.date_bin,
                             st_reg.hour24, st_reg.ds_en};
         IDX_STATC: rd_val = {st_reg.summary_irq_flag, st_reg.per_flg, st_reg.alm_flg,
                              st_reg.upd_flg, 4'h0};
         default: rd_val = 8'h00;
      endcase
      if (rd_data) begin
         st_next.rdata = rd_val;
         st_next.rvalid = 1'b1;
      end else if (rd_idx) begin
         st_next.rdata = st_reg.idx;
         st_next.rvalid = 1'b1;
      end

      // Only a data-port read of status C clears; an index read does not
      if (rd_data && st_reg.idx == IDX_STATC) begin
         st_next.per_flg = 1'b0;
         st_next.alm_flg = 1'b0;
         st_next.upd_flg = 1'b0;
         st_next.summary_irq_flag = 1'b0;
      end

      // Writes
      if (wr_idx) begin
         st_next.idx = io_wdata;
      end

      if (wr_data) begin
         case (st_reg.idx)
            IDX_MONTH: st_next.month = io_wdata;
            IDX_YEAR: st_next.year = io_wdata;
            IDX_CTLA: begin
               // Update flag bit is not writable
               st_next.dctl = io_wdata[CTLA_DCTL_LSB +: 3];
               st_next.rate = io_wdata[CTLA_RATE_LSB +: 4];
            end
            IDX_CTLB: begin
               st_next.set_b = io_wdata[CTLB_SET_BIT];
               st_next.per_en = io_wdata[CTLB_PER_EN_BIT];
               st_next.alm_en = io_wdata[CTLB_ALM_EN_BIT];
               // Setting inhibit also drops the update-ended enable
               st_next.upd_en = io_wdata[CTLB_UPD_EN_BIT] && !io_wdata[CTLB_SET_BIT];
               st_next.date_bin = io_wdata[CTLB_BIN_BIT];
               st_next.hour24 = io_wdata[CTLB_H24_BIT];
               st_next.ds_en = io_wdata[CTLB_DST_BIT];
            end
            default: st_next.idx = st_reg.idx;
         endcase
      end

      // Event flags; setting wins over the read clear
      if (per_evt) begin
         st_next.per_flg = 1'b1;
      end

      if (alarm_event) begin
         st_next.alm_flg = 1'b1;
      end

      if (update_end_event) begin
         st_next.upd_flg = 1'b1;
      end

      // Summary flag from an enabled rising flag or a late enable
      // A flag already set gives no new rise, so only a 0 to 1 edge counts
      per_rise = per_evt && !st_reg.per_flg && st_reg.per_en;
      alm_rise = alarm_event && !st_reg.alm_flg && st_reg.alm_en;
      upd_rise = update_end_event && !st_reg.upd_flg && st_reg.upd_en;

      // A late enable looks at the flag as it stood before this cycle
      per_late = st_next.per_en && !st_reg.per_en && st_reg.per_flg;
      alm_late = st_next.alm_en && !st_reg.alm_en && st_reg.alm_flg;
      upd_late = st_next.upd_en && !st_reg.upd_en && st_reg.upd_flg;

      if (per_rise || alm_rise || upd_rise ||
          per_late || alm_late || upd_late) begin
         st_next.summary_irq_flag = 1'b1;
      end
   end

   // Only the clock-only reset fields are cleared; the rest hold
   // Calendar, divider control and mode bits are left out on purpose:
   // software must find them unchanged after a clock-only reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg.idx <= 8'h00;
         st_reg.per_en <= 1'b0;
         st_reg.alm_en <= 1'b0;
         st_reg.upd_en <= 1'b0;
         st_reg.chain <= CHAIN_RESET;
         st_reg.acc <= '0;
         st_reg.per_flg <= 1'b0;
         st_reg.alm_flg <= 1'b0;
         st_reg.upd_flg <= 1'b0;
         st_reg.summary_irq_flag <= 1'b0;
         st_reg.rdata <= 8'h00;
         st_reg.rvalid <= 1'b0;
         st_reg.upd_pulse <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Every output is a field of the state register
   assign io_rdata = st_reg.rdata;
   assign io_rvalid = st_reg.rvalid;
   assign update_strobe = st_reg.upd_pulse;
   assign month_value = st_reg.month;
   assign year_value = st_reg.year;
   assign calendar_binary = st_reg.date_bin;
   assign hour_24 = st_reg.hour24;
   assign dst_enable = st_reg.ds_en;
   assign irq = st_reg.summary_irq_flag;
endmodule // rcc_top

//--- verification/rcc_asserts.sv
// Purpose: Port-level checker for rcc_top
// Assumes: Index and inhibit are tracked from port writes
// Notes: Bound to the top at the foot
module rcc_asserts
   import rcc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Port access
   input wire logic [7:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rvalid,
   // Calendar
   input wire logic month_carry,
   input wire logic update_strobe,
   input wire logic [7:0] month_value,
   input wire logic [7:0] year_value,
   input wire logic calendar_binary,
   input wire logic hour_24,
   input wire logic dst_enable
);
   logic [7:0] idx_reg;
   logic set_reg;
   logic dwr, drd, run;
   assign dwr = io_wr && io_addr == PORT_DATA;
   assign drd = io_rd && io_addr == PORT_DATA;
   assign run = month_carry && !dwr && !set_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idx_reg <= 8'h00;
      end else if (io_wr && io_addr == PORT_INDEX) begin
         idx_reg <= io_wdata;
      end
   end
   // Inhibit survives reset, like the device bit
   always_ff @(posedge clk) begin
      if (dwr && idx_reg == IDX_CTLB) begin
         set_reg <= io_wdata[CTLB_SET_BIT];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   read_answer_a: assert property (
      drd |=> io_rvalid) else $error("data read got no answer");
   answer_cause_a: assert property (
      io_rvalid |-> $past(io_rd)) else $error("answer without read");
   strobe_gap_a: assert property (
      update_strobe |=> !update_strobe [*8]) else $error("updates too close");
   cal_hold_a: assert property (
      !month_carry && !dwr |=> $stable(month_value) && $stable(year_value))
      else $error("calendar moved without update");
   month_wrap_a: assert property (
      run && month_value == 8'hFF |=> month_value == 8'h00) else $error("month no wrap");
   dec_roll_a: assert property (
      run && calendar_binary && month_value == MONTH_LAST_BIN && year_value == YEAR_LAST_BIN
      |=> month_value == MONTH_FIRST && year_value == YEAR_FIRST) else $error("bad rollover");
   bcd_roll_a: assert property (
      run && !calendar_binary && month_value == MONTH_LAST_BCD |=> month_value == MONTH_FIRST)
      else $error("bcd month rollover wrong");
   mode_out_a: assert property (
      dwr && idx_reg == IDX_CTLB |=> {calendar_binary, hour_24, dst_enable} == $past(io_wdata[2:0]))
      else $error("mode outputs wrong");
   month_read_a: assert property (
      drd && idx_reg == IDX_MONTH |=> io_rdata == $past(month_value)) else $error("month read");
   uip_clear_a: assert property (
      drd && idx_reg == IDX_CTLA && set_reg && $past(set_reg) |=> !io_rdata[CTLA_UIP_BIT])
      else $error("update flag set while inhibited");
   no_update_a: assert property (
      set_reg && $past(set_reg) |-> !update_strobe) else $error("update while inhibited");
   cover property (update_strobe);
   cover property (run && month_value == 8'hFF);
   cover property (drd && idx_reg == IDX_STATC);
endmodule // rcc_asserts

bind rcc_top rcc_asserts rcc_asserts_inst (.clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata,
   .io_rdata, .io_rvalid, .month_carry, .update_strobe, .month_value, .year_value,
   .calendar_binary, .hour_24, .dst_enable);

//--- verification/testbench.sv
// Purpose: Self-checking bench for rcc_top
// Assumes: Reserved divider code steps the chain every clock
// Notes: Reads queue expected data for a separate monitor
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import rcc_pkg::*;
   logic clk, rst, io_wr, io_rd, io_rvalid, month_carry, alarm_event, upd_ev, irq;
   logic [7:0] io_addr, io_wdata, io_rdata, month_value, year_value;
   logic update_strobe, calendar_binary, hour_24, dst_enable;
   logic [15:0] exp_q[$];
   logic [31:0] lfsr = 32'h445c_e2e3;
   logic [39:0] cal_tab[8] = '{40'h06_0C63_0100, 40'h06_0D05_0E05, 40'h06_FF63_0063,
      40'h06_0CFF_0100, 40'h06_0C70_0171, 40'h02_1299_0100, 40'h02_0905_1005,
      40'h86_0507_0507};
   logic [3:0] codes[4] = '{4'h5, 4'h6, 4'h1, 4'h2};
   int per[4] = '{16, 32, 128, 256};
   int n_mismatch = 0, comparisons = 0, cyc = 0, strobes = 0, t_st = 0;
   rcc_top rcc_top_inst (.clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
      .io_rvalid, .month_carry, .alarm_event, .update_end_event(upd_ev), .update_strobe,
      .month_value, .year_value, .calendar_binary, .hour_24, .dst_enable, .irq);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] lfsr_next(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (update_strobe === 1'b1) begin
         strobes <= strobes + 1;
         t_st <= cyc;
      end
      if (io_rvalid === 1'b1) begin
         chk("read data", exp_q[0][7:0], io_rdata & exp_q[0][15:8]);
         void'(exp_q.pop_front());
      end
      if (cyc == 90000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      #10;
      {io_wr, io_rd, io_addr, io_wdata} = {w, !w, a, d};
      @(posedge clk);
      #10;
      {io_wr, io_rd} = 2'b00;
   endtask
   task automatic wr(logic [7:0] i, logic [7:0] d);
      bus(1'b1, PORT_INDEX, i);
      bus(1'b1, PORT_DATA, d);
   endtask
   task automatic rd(logic [7:0] i, logic [7:0] e, logic [7:0] m);
      bus(1'b1, PORT_INDEX, i);
      exp_q.push_back({m, e & m});
      bus(1'b0, PORT_DATA, 8'h00);
   endtask
   task automatic pulse(logic [2:0] k);
      @(posedge clk);
      #10;
      {month_carry, alarm_event, upd_ev} = k;
      @(posedge clk);
      #10;
      {month_carry, alarm_event, upd_ev} = 3'b000;
   endtask
   task automatic cal(logic [39:0] v);
      wr(IDX_CTLB, v[39:32] | 8'h80);
      wr(IDX_MONTH, v[31:24]);
      wr(IDX_YEAR, v[23:16]);
      wr(IDX_CTLB, v[39:32]);
      pulse(3'b100);
      rd(IDX_MONTH, v[15:8], 8'hFF);
      rd(IDX_YEAR, v[7:0], 8'hFF);
   endtask
   task automatic wait_strobe();
      int s;
      s = strobes;
      for (int i = 0; i < 40000 && strobes == s; i++) @(posedge clk);
      @(posedge clk);
   endtask
   task automatic wait_irq();
      repeat (2) @(posedge clk);
      for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge clk);
   endtask
   initial begin
      int t1;
      logic [7:0] m, y;
      {rst, io_wr, io_rd, month_carry, alarm_event, upd_ev} = 6'b100000;
      {io_addr, io_wdata} = 16'h0000;
      repeat (4) @(posedge clk);
      #10 rst = 1'b0;
      wr(IDX_CTLB, 8'h8E);
      rd(IDX_CTLB, 8'h86, 8'hFF);
      wr(IDX_CTLA, 8'hE6);
      rd(IDX_CTLA, 8'h66, 8'hFF);
      rd(8'h3F, 8'h00, 8'hFF);
      foreach (cal_tab[k]) cal(cal_tab[k]);
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         m = 8'(lfsr[15:0] % 11) + 8'h01;
         y = 8'(lfsr[31:16] % 99);
         cal({8'h06, m, y, m + 8'h01, y});
      end
      $display("calendar test done");
      t1 = strobes;
      repeat (300) @(posedge clk);
      chk("held updates", t1, strobes);
      wr(IDX_CTLA, 8'h00);
      t1 = cyc;
      wait_strobe();
      chk("first update", 1, (t_st - t1) inside {[16380:16390]});
      t1 = t_st;
      while (cyc < t_st + 32760) @(posedge clk);
      rd(IDX_CTLA, 8'h80, 8'h80);
      wait_strobe();
      chk("update period", 32768, t_st - t1);
      rd(IDX_CTLA, 8'h00, 8'h80);
      $display("divider test done");
      rd(IDX_STATC, 8'h00, 8'h00);
      wr(IDX_CTLA, 8'h03);
      repeat (20) @(posedge clk);
      chk("irq disabled", 0, irq);
      wr(IDX_CTLB, 8'h46);
      repeat (2) @(posedge clk);
      chk("irq enabled", 1, irq);
      rd(IDX_STATC, 8'hC0, 8'hFF);
      for (int j = 0; j < 4; j++) begin
         wr(IDX_CTLA, {4'h0, codes[j]});
         // Two clears: one of them cannot meet a periodic event
         rd(IDX_STATC, 8'h00, 8'h00);
         rd(IDX_STATC, 8'h00, 8'h00);
         wait_irq();
         t1 = cyc;
         rd(IDX_STATC, 8'h00, 8'h00);
         wait_irq();
         chk("period", per[j], cyc - t1);
      end
      wr(IDX_CTLA, 8'h00);
      rd(IDX_STATC, 8'h00, 8'h00);
      repeat (300) @(posedge clk);
      rd(IDX_STATC, 8'h00, 8'hFF);
      wr(IDX_CTLB, 8'h26);
      pulse(3'b010);
      pulse(3'b001);
      rd(IDX_STATC, 8'hB0, 8'hFF);
      $display("periodic test done");
      wr(IDX_CTLA, 8'h66);
      wr(IDX_CTLB, 8'hC6);
      #10 rst = 1'b1;
      repeat (2) @(posedge clk);
      #10 rst = 1'b0;
      rd(IDX_CTLA, 8'h66, 8'h7F);
      rd(IDX_CTLB, 8'h86, 8'hFF);
      repeat (4) @(posedge clk);
      $display("reset test done");
      give_verdict();
   end
endmodule // testbench
